// ===== pmb_cfg.svh
// command codes, defaults, field positions and timing of the mfr bank
// assumes a 10 MHz core clock and a plain 7-bit bus address
`ifndef PMB_CFG_SVH
`define PMB_CFG_SVH
// command codes
`define PMB_C_USER4     8'hb4
`define PMB_C_INFO      8'hb6
`define PMB_C_SELFHEAT  8'hb8
`define PMB_C_TAU       8'hb9
`define PMB_C_THETA     8'hba
`define PMB_C_UNLOCK    8'hbd
`define PMB_C_ERASE     8'hbe
`define PMB_C_EEDATA    8'hbf
`define PMB_C_CHAN      8'hd0
`define PMB_C_GLOB      8'hd1
`define PMB_C_PROP      8'hd2
`define PMB_C_PWM       8'hd4
`define PMB_C_GRESP     8'hd5
`define PMB_C_OTRESP    8'hd6
`define PMB_C_IOUTPK    8'hd7
`define PMB_C_RETRY     8'hdb
`define PMB_C_RESTART   8'hdc
`define PMB_C_VOUTPK    8'hdd
`define PMB_C_VINPK     8'hde
`define PMB_C_TEMPPK    8'hdf
`define PMB_C_IINPK     8'he1
`define PMB_C_CLRPK     8'he3
`define PMB_C_ICHIP     8'he4
`define PMB_C_PADS      8'he5
`define PMB_C_ADDR      8'he6
`define PMB_C_ID        8'he7
`define PMB_C_IINGAIN   8'he8
// reset values
`define PMB_D_USER4     16'h0000
`define PMB_D_TAU       16'h8000
`define PMB_D_THETA     16'h8000
`define PMB_D_CHAN      8'h1f
`define PMB_D_GLOB      8'h09
`define PMB_D_PROP      16'h2993
`define PMB_D_PWM       8'hd2
`define PMB_D_GRESP     8'hc0
`define PMB_D_OTRESP    8'hc0
`define PMB_D_RETRY     16'hfabc
`define PMB_D_RESTART   16'hfbe8
`define PMB_D_ADDR      8'h4f
`define PMB_D_IINGAIN   16'hca80
`define PMB_D_ERASED    16'hffff
// value that opens the user eeprom
`define PMB_UNLOCK_KEY  8'h2b
// peak tracker slots
`define PMB_PK_IOUT     0
`define PMB_PK_VOUT     1
`define PMB_PK_VIN      2
`define PMB_PK_TEMP     3
`define PMB_PK_IIN      4
// timing
`define PMB_CLK_NS      100
`define PMB_MS_NS       1000000
`define PMB_MS_CYC      (`PMB_MS_NS / `PMB_CLK_NS)
`endif

// ===== pmb_pkg.sv
// types shared by the mfr command bank
// assumes nothing beyond the cfg header
package pmb_pkg;
  typedef logic [15:0] pmb_word_t;
  // nonvolatile working set, saved and reloaded as one unit
  typedef struct packed {
    logic [15:0] user4;
    logic [15:0] tau;
    logic [15:0] theta;
    logic [7:0]  chan;
    logic [7:0]  glob;
    logic [15:0] prop;
    logic [7:0]  pwm;
    logic [7:0]  gresp;
    logic [15:0] retry;
    logic [15:0] restart;
    logic [7:0]  addr;
    logic [15:0] iingain;
  } pmb_nv_t;
  // byte engine states, gray along the usual path
  typedef enum logic [2:0] {
    PMB_IDLE = 3'b000,
    PMB_RX   = 3'b001,
    PMB_ACK  = 3'b011,
    PMB_TX   = 3'b010,
    PMB_MACK = 3'b110
  } pmb_st_t;
endpackage

// ===== pmb_mfr_bank.sv
// mfr command bank behind a serial management bus slave
// assumes scl/sda and pads are asynchronous, telemetry is on clk
// Overview of operation
// - user word at b4, read/write, default zero
// - self heat reading at b8, read only
// - tau inverse word at b9, default 8000
// - thermal resistance word at ba, read/write
// - eeprom refused until unlock byte written
// - erase byte initialises eeprom for programming
// - data port word accesses step eeprom position
// - channel config 1f, global config 09
// - mask word selects faults onto fault pin
// - pwm engine config byte, default d2
// - fault pin pulled low takes action byte
// - overtemperature response read only byte c0
// - output current peak since last clear
// - retry interval in ms, default 350
// - run pin held low minimum ms time
// - output voltage peak, linear sixteen format
// - input voltage peak since last clear
// - temperature and input current peaks tracked
// - send byte e3 resets all peaks
// - pad state read only word
// - input sense resistance word, default ca80
// - nonvolatile set saved and restored whole
// - write to read only raises comm fault
`include "pmb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmb_mfr_bank #(
  parameter int        MS_CYC   = `PMB_MS_CYC,
  parameter int        EE_WORDS = 64,
  parameter logic [15:0] ID_WORD  = 16'h5a01, // arbitrary value
  parameter logic [15:0] INFO_WORD = 16'h0000
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // serial bus pins
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_oen,
  // telemetry from the loop, clk domain
  input  wire pmb_pkg::pmb_word_t meas[5],
  input  wire logic              meas_valid,
  input  wire pmb_pkg::pmb_word_t self_heat,
  input  wire pmb_pkg::pmb_word_t chip_current,
  // pads, asynchronous
  input  wire logic [15:0]       pads_i,
  // fault pin and fault sources
  input  wire logic              fault_pin_i,
  output logic                   fault_pin_oen,
  input  wire logic [15:0]       fault_events,
  input  wire logic              ot_fault,
  output logic [7:0]             gpio_action,
  output logic [7:0]             ot_action,
  // restart and retry timing
  input  wire logic              restart_req,
  input  wire logic              retry_req,
  output logic                   run_low,
  output logic                   retry_go,
  // store/restore and status
  input  wire logic              store_all,
  input  wire logic              restore_all,
  input  wire logic              comm_fault_clear,
  output logic                   comm_fault,
  output pmb_pkg::pmb_nv_t       cfg
);
  import pmb_pkg::*;

  // linear eleven word to a comparable signed key
  function automatic logic signed [47:0] lin_key(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0]         e;
    m = 48'(signed'(w[10:0]));
    e = w[15:11] + 5'd16;
    return m <<< e;
  endfunction

  // linear eleven milliseconds to a plain count
  function automatic logic [15:0] lin_ms(input logic [15:0] w);
    logic [31:0] m;
    logic [4:0]  ne;
    m  = {21'h0, w[10:0]};
    ne = 5'd0 - w[15:11];
    if (w[15]) return 16'(m >> ne);
    return 16'(m << w[15:11]);
  endfunction

  // synchronisers
  logic [2:0]  scl_q, sda_q; // stage 0 only feeds stage 1
  logic [15:0] pads_m_q, pads_q;
  logic        fpin_m_q, fpin_q;
  // byte engine
  pmb_st_t     st_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q, cmd_q, dlo_q, dhi_q;
  logic [2:0]  idx_q;
  logic        rd_q, hit_q, txi_q, nack_q, sda_oen_q;
  // register storage
  pmb_nv_t     nv_q, shadow_q;
  logic        unlocked_q, comm_fault_q;
  logic [5:0]  ptr_q;
  logic [15:0] mem_q [EE_WORDS];
  logic [15:0] pk_q [5];
  logic [4:0]  pk_ok_q;
  // timers and actions
  logic [15:0] tick_cnt_q, run_cnt_q, rty_cnt_q;
  logic        tick, run_low_q, retry_go_q, fpin_oen_q;
  logic [7:0]  gact_q, otact_q;

  // pin edges seen on the synchronised copies
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire bus_stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  // committed write on stop
  wire       wr_go   = bus_stop & hit_q & ~rd_q & (idx_q >= 3'd2);
  wire       wr_send = wr_go & (idx_q == 3'd2);
  wire       wr_data = wr_go & (idx_q != 3'd2);
  wire [15:0] wdat   = {dhi_q, dlo_q};
  wire       clr_go  = wr_send & (cmd_q == `PMB_C_CLRPK);
  wire       ee_wr   = wr_data & (cmd_q == `PMB_C_EEDATA);
  wire       ee_er   = wr_data & (cmd_q == `PMB_C_ERASE);
  wire       ee_rd   = (st_q == PMB_MACK) & scl_fall & ~nack_q & ~txi_q
                       & (cmd_q == `PMB_C_EEDATA) & unlocked_q;
  logic      wr_ro;

  // read value of the addressed command
  logic [15:0] rdata;
  always_comb begin
    rdata = 16'h0000;
    case (cmd_q)
      `PMB_C_USER4:    rdata = nv_q.user4;
      `PMB_C_INFO:     rdata = INFO_WORD;
      `PMB_C_SELFHEAT: rdata = self_heat;
      `PMB_C_TAU:      rdata = nv_q.tau;
      `PMB_C_THETA:    rdata = nv_q.theta;
      `PMB_C_UNLOCK:   rdata = {15'h0, unlocked_q};
      `PMB_C_EEDATA:   rdata = unlocked_q ? mem_q[ptr_q] : 16'h0000;
      `PMB_C_CHAN:     rdata = {8'h0, nv_q.chan};
      `PMB_C_GLOB:     rdata = {8'h0, nv_q.glob};
      `PMB_C_PROP:     rdata = nv_q.prop;
      `PMB_C_PWM:      rdata = {8'h0, nv_q.pwm};
      `PMB_C_GRESP:    rdata = {8'h0, nv_q.gresp};
      `PMB_C_OTRESP:   rdata = {8'h0, `PMB_D_OTRESP};
      `PMB_C_IOUTPK:   rdata = pk_q[`PMB_PK_IOUT];
      `PMB_C_RETRY:    rdata = nv_q.retry;
      `PMB_C_RESTART:  rdata = nv_q.restart;
      `PMB_C_VOUTPK:   rdata = pk_q[`PMB_PK_VOUT];
      `PMB_C_VINPK:    rdata = pk_q[`PMB_PK_VIN];
      `PMB_C_TEMPPK:   rdata = pk_q[`PMB_PK_TEMP];
      `PMB_C_IINPK:    rdata = pk_q[`PMB_PK_IIN];
      `PMB_C_ICHIP:    rdata = chip_current;
      `PMB_C_PADS:     rdata = pads_q;
      `PMB_C_ADDR:     rdata = {8'h0, nv_q.addr};
      `PMB_C_ID:       rdata = ID_WORD;
      `PMB_C_IINGAIN:  rdata = nv_q.iingain;
      default:         rdata = 16'h0000;
    endcase
  end

  // read only and unknown codes, plus refused eeprom access
  always_comb begin
    case (cmd_q)
      `PMB_C_USER4, `PMB_C_TAU, `PMB_C_THETA, `PMB_C_CHAN,
      `PMB_C_GLOB, `PMB_C_PROP, `PMB_C_PWM, `PMB_C_GRESP,
      `PMB_C_RETRY, `PMB_C_RESTART, `PMB_C_ADDR, `PMB_C_IINGAIN,
      `PMB_C_UNLOCK: wr_ro = 1'b0;
      `PMB_C_ERASE, `PMB_C_EEDATA: wr_ro = ~unlocked_q;
      default: wr_ro = 1'b1;
    endcase
  end

  // two flop synchronisers for pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q    <= 3'h7;
      sda_q    <= 3'h7;
      pads_m_q <= 16'h0000;
      pads_q   <= 16'h0000;
      fpin_m_q <= 1'b1;
      fpin_q   <= 1'b1;
    end else begin
      scl_q    <= {scl_q[1:0], scl_i};
      sda_q    <= {sda_q[1:0], sda_i};
      pads_m_q <= pads_i;
      pads_q   <= pads_m_q;
      fpin_m_q <= fault_pin_i;
      fpin_q   <= fpin_m_q;
    end
  end

  // byte engine: address, command, data, acknowledge, read out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= PMB_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 3'h0;
      cmd_q <= 8'h00;
      dlo_q <= 8'h00;
      dhi_q <= 8'h00;
      rd_q <= 1'b0;
      hit_q <= 1'b0;
      txi_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oen_q <= 1'b1;
    end else if (bus_start) begin
      // start or repeated start keeps the command byte
      st_q <= PMB_RX;
      bit_q <= 4'h0;
      idx_q <= 3'h0;
      hit_q <= 1'b0;
      sda_oen_q <= 1'b1;
    end else if (bus_stop) begin
      st_q <= PMB_IDLE;
      hit_q <= 1'b0;
      rd_q <= 1'b0;
      sda_oen_q <= 1'b1;
    end else begin
      case (st_q)
        PMB_RX: begin
          if (scl_rise && bit_q != 4'h8) begin
            sh_q <= {sh_q[6:0], sda_q[1]};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            if (idx_q == 3'h0) begin
              // match on the stored address
              if (sh_q[7:1] == nv_q.addr[6:0]) begin
                hit_q <= 1'b1;
                rd_q <= sh_q[0];
                txi_q <= 1'b0;
                sda_oen_q <= 1'b0;
                st_q <= PMB_ACK;
              end else begin
                st_q <= PMB_IDLE;
              end
            end else begin
              if (idx_q == 3'h1) cmd_q <= sh_q;
              if (idx_q == 3'h2) dlo_q <= sh_q;
              if (idx_q == 3'h3) dhi_q <= sh_q;
              sda_oen_q <= 1'b0;
              st_q <= PMB_ACK;
            end
            if (idx_q != 3'h7) idx_q <= idx_q + 3'h1;
          end
        end
        PMB_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              // low byte first, then high
              sh_q <= rdata[7:0];
              sda_oen_q <= rdata[7];
              bit_q <= 4'h1;
              st_q <= PMB_TX;
            end else begin
              sda_oen_q <= 1'b1;
              bit_q <= 4'h0;
              st_q <= PMB_RX;
            end
          end
        end
        PMB_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_oen_q <= 1'b1;
              st_q <= PMB_MACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b1};
              sda_oen_q <= sh_q[6];
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        PMB_MACK: begin
          if (scl_rise) begin
            nack_q <= sda_q[1];
          end else if (scl_fall) begin
            if (nack_q) begin
              st_q <= PMB_IDLE;
            end else begin
              sh_q <= txi_q ? rdata[7:0] : rdata[15:8];
              sda_oen_q <= txi_q ? rdata[7] : rdata[15];
              txi_q <= ~txi_q;
              bit_q <= 4'h1;
              st_q <= PMB_TX;
            end
          end
        end
        default: st_q <= PMB_IDLE;
      endcase
    end
  end

  // nonvolatile working set and its saved copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_q <= '{`PMB_D_USER4, `PMB_D_TAU, `PMB_D_THETA,
                `PMB_D_CHAN, `PMB_D_GLOB, `PMB_D_PROP,
                `PMB_D_PWM, `PMB_D_GRESP, `PMB_D_RETRY,
                `PMB_D_RESTART, `PMB_D_ADDR, `PMB_D_IINGAIN};
      shadow_q <= '{`PMB_D_USER4, `PMB_D_TAU, `PMB_D_THETA,
                    `PMB_D_CHAN, `PMB_D_GLOB, `PMB_D_PROP,
                    `PMB_D_PWM, `PMB_D_GRESP, `PMB_D_RETRY,
                    `PMB_D_RESTART, `PMB_D_ADDR, `PMB_D_IINGAIN};
    end else begin
      if (store_all) shadow_q <= nv_q;
      if (restore_all) begin
        nv_q <= shadow_q;
      end else if (wr_data) begin
        case (cmd_q)
          `PMB_C_USER4:   nv_q.user4 <= wdat;
          `PMB_C_TAU:     nv_q.tau <= wdat;
          `PMB_C_THETA:   nv_q.theta <= wdat;
          `PMB_C_CHAN:    nv_q.chan <= dlo_q;
          `PMB_C_GLOB:    nv_q.glob <= dlo_q;
          `PMB_C_PROP:    nv_q.prop <= wdat;
          `PMB_C_PWM:     nv_q.pwm <= dlo_q;
          `PMB_C_GRESP:   nv_q.gresp <= dlo_q;
          `PMB_C_RETRY:   nv_q.retry <= wdat;
          `PMB_C_RESTART: nv_q.restart <= wdat;
          `PMB_C_ADDR:    nv_q.addr <= {1'b0, dlo_q[6:0]};
          `PMB_C_IINGAIN: nv_q.iingain <= wdat;
          default:        nv_q <= nv_q;
        endcase
      end
    end
  end

  // comm fault flag, a new fault wins over a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) comm_fault_q <= 1'b0;
    else if (wr_data && wr_ro) comm_fault_q <= 1'b1;
    else if (comm_fault_clear) comm_fault_q <= 1'b0;
  end

  // eeprom lock, erase and sequential data port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_q <= 1'b0;
      ptr_q <= 6'h00;
    end else if (wr_data && cmd_q == `PMB_C_UNLOCK) begin
      unlocked_q <= (dlo_q == `PMB_UNLOCK_KEY);
    end else if (ee_er && unlocked_q) begin
      ptr_q <= 6'h00;
    end else if ((ee_wr && unlocked_q) || ee_rd) begin
      ptr_q <= ptr_q + 6'h01;
    end
  end

  // eeprom array, one writer per entry
  for (genvar g = 0; g < EE_WORDS; g++) begin : g_ee
    always_ff @(posedge clk) begin
      if (ee_er && unlocked_q) mem_q[g] <= `PMB_D_ERASED;
      else if (ee_wr && unlocked_q && ptr_q == 6'(g)) mem_q[g] <= wdat;
    end
  end

  // peak trackers, first sample after a clear is taken as is
  for (genvar p = 0; p < 5; p++) begin : g_pk
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pk_q[p] <= 16'h0000;
        pk_ok_q[p] <= 1'b0;
      end else if (clr_go) begin
        pk_ok_q[p] <= 1'b0;
      end else if (meas_valid) begin
        if (!pk_ok_q[p] ||
            (p == `PMB_PK_VOUT ? meas[p] > pk_q[p]
                               : lin_key(meas[p]) > lin_key(pk_q[p]))) begin
          pk_q[p] <= meas[p];
        end
        pk_ok_q[p] <= 1'b1;
      end
    end
  end

  // millisecond tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tick_cnt_q <= 16'h0000;
    else if (tick) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick_cnt_q + 16'h0001;
  end
  assign tick = (tick_cnt_q == 16'(MS_CYC - 1));

  // run pin hold low, one extra ms covers the partial first one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cnt_q <= 16'h0000;
      run_low_q <= 1'b0;
    end else if (restart_req) begin
      run_cnt_q <= lin_ms(nv_q.restart) + 16'h0001;
      run_low_q <= 1'b1;
    end else if (run_cnt_q == 16'h0000) begin
      run_low_q <= 1'b0;
    end else if (tick) begin
      run_cnt_q <= run_cnt_q - 16'h0001;
    end
  end

  // retry wait, then a one cycle go pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rty_cnt_q <= 16'h0000;
      retry_go_q <= 1'b0;
    end else begin
      retry_go_q <= 1'b0;
      if (retry_req) begin
        rty_cnt_q <= lin_ms(nv_q.retry) + 16'h0001;
      end else if (tick && rty_cnt_q != 16'h0000) begin
        rty_cnt_q <= rty_cnt_q - 16'h0001;
        retry_go_q <= (rty_cnt_q == 16'h0001);
      end
    end
  end

  // fault pin drive and fault responses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fpin_oen_q <= 1'b1;
      gact_q <= 8'h00;
      otact_q <= 8'h00;
    end else begin
      fpin_oen_q <= ~|(fault_events & nv_q.prop);
      gact_q <= (!fpin_q && fpin_oen_q) ? nv_q.gresp : 8'h00;
      otact_q <= ot_fault ? `PMB_D_OTRESP : 8'h00;
    end
  end

  // outputs straight from flops
  assign sda_oen = sda_oen_q;
  assign fault_pin_oen = fpin_oen_q;
  assign gpio_action = gact_q;
  assign ot_action = otact_q;
  assign run_low = run_low_q;
  assign retry_go = retry_go_q;
  assign comm_fault = comm_fault_q;
  assign cfg = nv_q;

  // checks
  a_ot_response: assert property (@(posedge clk) disable iff (!rst_n)
    ot_fault |=> ot_action == 8'hc0) else $error("ot response wrong");
  a_peak_clear: assert property (@(posedge clk) disable iff (!rst_n)
    clr_go |=> pk_ok_q == 5'h00) else $error("peaks not cleared");
  a_locked_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    ee_wr && !unlocked_q |=> $stable(ptr_q) && comm_fault) else $error("locked write taken");
  a_erase_ptr: assert property (@(posedge clk) disable iff (!rst_n)
    ee_er && unlocked_q |=> ptr_q == 6'h00) else $error("erase left pointer");
  a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
    ee_wr && unlocked_q && !restore_all |=> ptr_q == $past(ptr_q) + 6'h01)
    else $error("pointer did not step");
  a_ro_flag: assert property (@(posedge clk) disable iff (!rst_n)
    wr_data && cmd_q == `PMB_C_OTRESP |=> comm_fault && $stable(nv_q)) else $error("ro write");
  a_mask_drive: assert property (@(posedge clk) disable iff (!rst_n)
    |(fault_events & nv_q.prop) && !restore_all && !wr_data |=> !fault_pin_oen)
    else $error("fault pin not driven");
  a_restore_set: assert property (@(posedge clk) disable iff (!rst_n)
    restore_all |=> cfg == $past(shadow_q)) else $error("restore failed");
  a_run_hold: assert property (@(posedge clk) disable iff (!rst_n)
    restart_req |=> run_low ##1 run_low) else $error("run not held");
endmodule
`default_nettype wire

// ===== pmb_host.sv
// bus host model that drives the mfr bank's serial pins
// assumes sda_w is the wired-and level of both drivers with a pull-up
`include "pmb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmb_host (
  // core clock and resolved data line
  input  wire logic clk,
  input  wire logic sda_w,
  // pins, high means released
  output logic      scl,
  output logic      sda
);
  logic [7:0] adr;  // target address, low seven bits
  initial begin
    adr = `PMB_D_ADDR;
    scl = 1'b1;
    sda = 1'b1;
  end
  // wait n core clocks
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bit: scl low 8 clocks, high 6, line sampled mid high
  task automatic bit1(input logic b, output logic r);
    tk(2);
    sda <= b;
    tk(6);
    scl <= 1'b1;
    tk(3);
    r = sda_w;
    tk(3);
    scl <= 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    tk(2);
    sda <= 1'b1;
    tk(4);
    scl <= 1'b1;
    tk(4);
    sda <= 1'b0;
    tk(4);
    scl <= 1'b0;
  endtask
  // stop, then bus idle
  task automatic stop();
    tk(2);
    sda <= 1'b0;
    tk(4);
    scl <= 1'b1;
    tk(4);
    sda <= 1'b1;
    tk(6);
  endtask
  // byte msb first, then ack bit (1 releases the line)
  task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], q[i]);
    end
    bit1(ak, a);
  endtask
  // word write low byte first, or send byte when w is 0
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic w);
    logic [7:0] q;
    start();
    xbyte({adr[6:0], 1'b0}, 1'b1, q);
    xbyte(c, 1'b1, q);
    if (w) begin
      xbyte(d[7:0], 1'b1, q);
      xbyte(d[15:8], 1'b1, q);
    end
    stop();
  endtask
  // word read: ack low byte, nack high byte
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    logic [7:0] q;
    start();
    xbyte({adr[6:0], 1'b0}, 1'b1, q);
    xbyte(c, 1'b1, q);
    start();
    xbyte({adr[6:0], 1'b1}, 1'b1, q);
    xbyte(8'hff, 1'b0, d[7:0]);
    xbyte(8'hff, 1'b1, d[15:8]);
    stop();
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the mfr command bank
// assumes the host model drives the bus; eeprom unlock key is 2b
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmb_pkg::*;
  typedef struct packed {
    logic [7:0]  c;
    logic [15:0] d;
    logic [15:0] w;
    logic        b;
    logic        ro;
  } pmb_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl, hsda, sda_oen, fp_oen, run_low, retry_go, comm_flt;
  logic        fdrv = 1'b1;
  logic        ot = 1'b0;
  logic [5:0]  pl = 6'h00;  // pulses: valid, restart, retry, store, restore, clear
  logic [15:0] fev = 16'h0000;
  logic [15:0] q;
  logic [7:0]  gact, oact;
  pmb_word_t   meas[5];
  pmb_nv_t     cfg;
  pmb_row_t    rows[16];
  int          n_errors = 0;
  int          total_checks = 0;
  int          cnt;
  wire logic   sda_w = hsda & sda_oen;  // pull-up on the data line
  always #50 clk = ~clk;
  pmb_host pmb_host_i (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(hsda));
  // id word value is arbitrary
  pmb_mfr_bank #(.MS_CYC(10), .ID_WORD(16'h5a01)) pmb_mfr_bank_i (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_oen(sda_oen),
    .meas(meas), .meas_valid(pl[0]), .self_heat(16'h0abc), .chip_current(16'h0042),
    .pads_i(16'h1234), .fault_pin_i(fdrv & fp_oen), .fault_pin_oen(fp_oen),
    .fault_events(fev), .ot_fault(ot), .gpio_action(gact), .ot_action(oact),
    .restart_req(pl[1]), .retry_req(pl[2]), .run_low(run_low), .retry_go(retry_go),
    .store_all(pl[3]), .restore_all(pl[4]), .comm_fault_clear(pl[5]),
    .comm_fault(comm_flt), .cfg(cfg));
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic pulse(input int i);
    pl[i] <= 1'b1;
    tk(1);
    pl[i] <= 1'b0;
    tk(1);
  endtask
  task automatic samp(input logic [15:0] v);
    foreach (meas[i]) meas[i] <= v;
    pulse(0);
  endtask
  task automatic peaks(input logic [15:0] e);
    logic [7:0] pk[5] = '{8'hd7, 8'hdd, 8'hde, 8'hdf, 8'he1};
    foreach (pk[i]) begin
      pmb_host_i.rd(pk[i], q);
      chk(q, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    tk(95000);
    n_errors++;
    complete_run();
  end
  initial begin
    foreach (meas[i]) meas[i] = 16'h0000;
    rows = '{'{8'hb4, 16'h0000, 16'h1234, 1'b0, 1'b0}, '{8'hb9, 16'h8000, 16'h8001, 1'b0, 1'b0},
      '{8'hba, 16'h8000, 16'h8002, 1'b0, 1'b0}, '{8'hd0, 16'h001f, 16'h0011, 1'b1, 1'b0},
      '{8'hd1, 16'h0009, 16'h0008, 1'b1, 1'b0}, '{8'hd2, 16'h2993, 16'h2991, 1'b0, 1'b0},
      '{8'hd4, 16'h00d2, 16'h00d3, 1'b1, 1'b0}, '{8'hd5, 16'h00c0, 16'h00c1, 1'b1, 1'b0},
      '{8'hdb, 16'hfabc, 16'hfabc, 1'b0, 1'b0}, '{8'hdc, 16'hfbe8, 16'hfbe8, 1'b0, 1'b0},
      '{8'he8, 16'hca80, 16'hca81, 1'b0, 1'b0}, '{8'he6, 16'h004f, 16'h004f, 1'b1, 1'b0},
      '{8'hd6, 16'h00c0, 16'h0055, 1'b1, 1'b1}, '{8'hb8, 16'h0abc, 16'h1111, 1'b0, 1'b1},
      '{8'he5, 16'h1234, 16'h0000, 1'b0, 1'b1}, '{8'he7, 16'h5a01, 16'h0000, 1'b0, 1'b1}};
    tk(8);
    rst_n <= 1'b1;
    tk(4);
    foreach (rows[i]) begin
      pmb_host_i.rd(rows[i].c, q);
      chk(rows[i].b ? q & 16'h00ff : q, rows[i].d);
      pmb_host_i.wr(rows[i].c, rows[i].w, 1'b1);
      tk(3);
      chk({15'h0, comm_flt}, {15'h0, rows[i].ro});
      pulse(5);
      pmb_host_i.rd(rows[i].c, q);
      chk(rows[i].b ? q & 16'h00ff : q, rows[i].ro ? rows[i].d : rows[i].w);
    end
    $display("test registers done");
    fdrv <= 1'b0;
    tk(6);
    chk({8'h0, gact}, 16'h00c1);
    fdrv <= 1'b1;
    fev <= 16'h0001;
    tk(4);
    chk({15'h0, fp_oen}, 16'h0000);
    fev <= 16'h0004;
    ot <= 1'b1;
    tk(4);
    chk({15'h0, fp_oen}, 16'h0001);
    chk({8'h0, oact}, 16'h00c0);
    ot <= 1'b0;
    pulse(3);
    pmb_host_i.wr(8'hb4, 16'hbeef, 1'b1);
    chk(cfg.user4, 16'hbeef);
    pulse(4);
    chk(cfg.user4, 16'h1234);
    $display("test pins and store done");
    samp(16'h0030);
    samp(16'h0020);
    peaks(16'h0030);
    pmb_host_i.wr(8'he3, 16'h0000, 1'b0);
    samp(16'h0010);
    peaks(16'h0010);
    $display("test peaks done");
    pmb_host_i.wr(8'hbf, 16'h1111, 1'b1);
    tk(3);
    chk({15'h0, comm_flt}, 16'h0001);
    pmb_host_i.rd(8'hbf, q);
    chk(q, 16'h0000);
    pmb_host_i.wr(8'hbd, 16'h002b, 1'b1);
    pmb_host_i.wr(8'hbe, 16'h0000, 1'b1);
    pmb_host_i.rd(8'hbf, q);
    chk(q, 16'hffff);
    pmb_host_i.wr(8'hbf, 16'ha5a5, 1'b1);
    pmb_host_i.wr(8'hbf, 16'h5a5a, 1'b1);
    rst_n <= 1'b0;
    tk(2);
    rst_n <= 1'b1;
    tk(4);
    chk(cfg.user4, 16'h0000);
    pmb_host_i.wr(8'hbd, 16'h002b, 1'b1);
    pmb_host_i.rd(8'hbf, q);
    pmb_host_i.rd(8'hbf, q);
    chk(q, 16'ha5a5);
    pmb_host_i.rd(8'hbf, q);
    chk(q, 16'h5a5a);
    $display("test eeprom done");
    pulse(1);
    for (cnt = 0; run_low === 1'b1 && cnt < 6000; cnt++) tk(1);
    chk({15'h0, cnt >= 4990 && cnt <= 5012}, 16'h0001);
    pulse(2);
    for (cnt = 0; retry_go !== 1'b1 && cnt < 6000; cnt++) tk(1);
    chk({15'h0, cnt >= 3490 && cnt <= 3512}, 16'h0001);
    $display("test timers done");
    complete_run();
  end
endmodule
`default_nettype wire
